//--- design/boot_pkg.sv
// Constants, types and register map of the reset-time boot sequencer
package boot_pkg;

	// ==========================================================
	// Memory map and access timing
	localparam logic [15:0] SEL_ADDR         = 16'hffff;
	localparam logic [15:0] GLOBAL_LO        = 16'h8000;
	localparam logic [15:0] GLOBAL_HI        = 16'hffff;
	localparam logic [2:0]  BOOT_WAIT_STATES = 3'h7;
	// One setup cycle, then the strobe for 1 + wait states cycles
	localparam logic [3:0]  ACCESS_LAST      = 4'h8;
	localparam int          PAGE_SHIFT       = 10;

	// ==========================================================
	// Read-to-write gap, in instruction cycles and pclk cycles
	localparam int CLK_PERIOD_NS  = 4;
	localparam int INSTR_CYCLE_NS = 4;
	localparam int GAP_MIN_INSTR  = 4;
	localparam int GAP_CYCLES     =
		(GAP_MIN_INSTR * INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] GAP_LAST = 4'(GAP_CYCLES - 1);

	// ==========================================================
	// Selection byte layout
	localparam int         SEL_PAGE_LSB = 2;
	localparam int         SEL_PAGE_MSB = 7;
	localparam logic [1:0] SEL_SERIAL_IO = 2'h0;
	localparam logic [1:0] SEL_EPROM8    = 2'h1;
	localparam logic [1:0] SEL_EPROM16   = 2'h2;
	localparam logic [1:0] SEL_WARM      = 2'h3;

	// ==========================================================
	// Register offsets and fields
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_COUNT   = 8'h08;
	localparam logic [7:0] REG_TARGET  = 8'h0c;
	localparam int CTRL_RESTART   = 0;
	localparam int STAT_BUSY      = 0;
	localparam int STAT_DONE      = 1;
	localparam int STAT_MP_PIN    = 2;
	localparam int STAT_MODE_LSB  = 4;
	localparam int STAT_SEL_LSB   = 8;

	typedef enum logic [2:0] {
		MODE_NONE    = 3'h0,
		MODE_SER8    = 3'h1,
		MODE_SER16   = 3'h2,
		MODE_IO8     = 3'h3,
		MODE_IO16    = 3'h4,
		MODE_EPROM8  = 3'h5,
		MODE_EPROM16 = 3'h6,
		MODE_WARM    = 3'h7
	} boot_mode_e;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h0,
		ST_CONFIG  = 4'h1,
		ST_SEL_RD  = 4'h2,
		ST_DECODE  = 4'h3,
		ST_WORD_RD = 4'h4,
		ST_GAP     = 4'h5,
		ST_PM_WR   = 4'h6,
		ST_FINISH  = 4'h7,
		ST_BRANCH  = 4'h8,
		ST_HANDOFF = 4'h9
	} boot_state_e;

	typedef struct packed {
		logic       int_disable;
		logic       block_zero_program_map;
		logic       single_access_prog_en;
		logic       data_space_overlay_select;
		logic [2:0] prog_wait;
		logic [2:0] data_wait;
		logic       global_mem_en;
	} boot_cfg_s;

	typedef struct packed {
		logic [15:0] addr;
		logic        global_bus_request_n;
		logic        data_space_strobe_n;
	} ext_req_s;

endpackage : boot_pkg

//--- design/boot_loader_sequencer.sv
// Reset-time boot sequencer: memory setup, mode fetch and EPROM code copy
//
// Overview of operation
// - Mode pin low at reset starts the boot sequence from its first step.
// - First: interrupts off, block zero to program, overlay cleared.
// - Seven wait states on all program and data external accesses.
// - Global data memory 08000h to 0FFFFh enabled during boot.
// - Global data memory disabled after copy, before branching.
// - Selection word read from 0FFFFh with bus request and strobe low.
// - Only low eight bits of the selection word choose the mode.
// - Low nibble 0000/0100/1000/1100 picks serial or I/O boot variants.
// - Low bits 01 byte EPROM, 10 word EPROM; page gives top six bits.
// - Word EPROM: read words, source address plus one after each read.
// - Length is code words minus one; copy length plus one words.
// - At least four instruction cycles between source read and write.
// - After the copy, branch to the header destination address.
// - Byte EPROM: two locations form one word, high byte first.
// - Byte reads use data lines 7..0 and ignore the upper byte.
// - Byte image length is half the code bytes minus one.
// - Warm boot takes a six-bit page field as its entry point.
// - Warm boot copies nothing and jumps straight to the entry.
`timescale 1ns/1ns

module boot_loader_sequencer (
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB register port
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	// Strap
	input  wire logic                microcomputer_mode_pin,
	// External global data bus, read only
	output boot_pkg::ext_req_s       ext_req,
	input  wire logic [15:0]         ext_rdata,
	// Program memory write port
	output logic [15:0]              pm_addr,
	output logic [15:0]              pm_wdata,
	output logic                     pm_we,
	// Processor configuration and hand-over
	output boot_pkg::boot_cfg_s      boot_cfg,
	output logic                     global_hit,
	output logic                     branch_valid,
	output logic [15:0]              branch_addr,
	output logic                     handoff_valid,
	output boot_pkg::boot_mode_e     handoff_mode,
	output logic                     boot_busy
);

	// ==========================================================
	// Helpers and state
	function automatic logic [15:0] page_addr(input logic [5:0] page);
		page_addr = 16'(page) << boot_pkg::PAGE_SHIFT;
	endfunction : page_addr
	boot_pkg::boot_state_e state_ff, nxt_state;
	boot_pkg::boot_mode_e  mode_ff;
	boot_pkg::boot_cfg_s   cfg_ff;
	logic        arm_ff;
	logic        mp_pin_ff;
	logic        done_ff;
	logic [3:0]  acc_cnt_ff;
	logic [3:0]  gap_cnt_ff;
	logic [15:0] src_addr_ff;
	logic [7:0]  sel_ff;
	logic        byte_mode_ff;
	logic        high_half_ff;
	logic [7:0]  high_byte_ff;
	logic [1:0]  word_idx_ff;
	logic [15:0] dest_ff;
	logic [15:0] len_ff;
	logic [15:0] copied_ff;
	logic [15:0] word_ff;
	logic [15:0] pm_addr_ff;
	logic        restart_ff;

	// ==========================================================
	// Decode
	wire         reading    = (state_ff == boot_pkg::ST_SEL_RD) ||
	                          (state_ff == boot_pkg::ST_WORD_RD);
	wire         acc_done   = reading && (acc_cnt_ff == boot_pkg::ACCESS_LAST);
	wire [7:0]   sel_byte   = ext_rdata[7:0];
	wire [1:0]   sel_low    = sel_ff[1:0];
	wire [5:0]   sel_page   = sel_ff[boot_pkg::SEL_PAGE_MSB:
	                                 boot_pkg::SEL_PAGE_LSB];
	wire [15:0]  asm_word   = byte_mode_ff ?
	                          {high_byte_ff, ext_rdata[7:0]} :
	                          ext_rdata;
	wire         need_low   = byte_mode_ff && !high_half_ff;
	wire         last_word  = (copied_ff == len_ff);
	wire         apb_setup  = psel && !penable;
	wire         apb_access = psel && penable;
	wire         hit_ctrl   = (paddr == boot_pkg::REG_CTRL);
	wire         hit_status = (paddr == boot_pkg::REG_STATUS);
	wire         hit_count  = (paddr == boot_pkg::REG_COUNT);
	wire         hit_target = (paddr == boot_pkg::REG_TARGET);
	wire         hit_any    = hit_ctrl | hit_status | hit_count | hit_target;
	wire         wr_ctrl    = apb_access && pwrite && hit_ctrl;
	wire         soft_start = restart_ff && (state_ff == boot_pkg::ST_IDLE);
	wire         strap_go   = arm_ff && !microcomputer_mode_pin;

	boot_pkg::boot_mode_e sel_mode;
	always_comb begin
		unique case (sel_low)
			boot_pkg::SEL_EPROM8:  sel_mode = boot_pkg::MODE_EPROM8;
			boot_pkg::SEL_EPROM16: sel_mode = boot_pkg::MODE_EPROM16;
			boot_pkg::SEL_WARM:    sel_mode = boot_pkg::MODE_WARM;
			boot_pkg::SEL_SERIAL_IO: begin
				// Upper nibble is a don't-care here
				unique case (sel_ff[3:2])
					2'h0: sel_mode = boot_pkg::MODE_SER8;
					2'h1: sel_mode = boot_pkg::MODE_SER16;
					2'h2: sel_mode = boot_pkg::MODE_IO8;
					2'h3: sel_mode = boot_pkg::MODE_IO16;
				endcase
			end
		endcase
	end

	// ==========================================================
	// Sequencer next state
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			boot_pkg::ST_IDLE:
				if (strap_go || soft_start)
					nxt_state = boot_pkg::ST_CONFIG;
			boot_pkg::ST_CONFIG:
				nxt_state = boot_pkg::ST_SEL_RD;
			boot_pkg::ST_SEL_RD:
				if (acc_done)
					nxt_state = boot_pkg::ST_DECODE;
			boot_pkg::ST_DECODE:
				if (sel_mode == boot_pkg::MODE_EPROM8 ||
				    sel_mode == boot_pkg::MODE_EPROM16)
					nxt_state = boot_pkg::ST_WORD_RD;
				else if (sel_mode == boot_pkg::MODE_WARM)
					nxt_state = boot_pkg::ST_FINISH;
				else
					nxt_state = boot_pkg::ST_HANDOFF;
			boot_pkg::ST_WORD_RD:
				if (acc_done && !need_low && word_idx_ff == 2'h2)
					nxt_state = boot_pkg::ST_GAP;
			boot_pkg::ST_GAP:
				if (gap_cnt_ff == boot_pkg::GAP_LAST)
					nxt_state = boot_pkg::ST_PM_WR;
			boot_pkg::ST_PM_WR:
				nxt_state = last_word ? boot_pkg::ST_FINISH :
				                        boot_pkg::ST_WORD_RD;
			boot_pkg::ST_FINISH:
				nxt_state = boot_pkg::ST_BRANCH;
			boot_pkg::ST_BRANCH, boot_pkg::ST_HANDOFF:
				nxt_state = boot_pkg::ST_IDLE;
			default:
				nxt_state = boot_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_ff <= boot_pkg::ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// ==========================================================
	// Strap capture: armed by reset, pin sampled on the first edge after it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_ff    <= 1'b1;
			mp_pin_ff <= 1'b1;
		end else if (arm_ff) begin
			// One look only: a pin that falls later must not start a boot
			arm_ff    <= 1'b0;
			mp_pin_ff <= microcomputer_mode_pin;
		end
	end

	// ==========================================================
	// Processor configuration; reset leaves interrupts masked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= '{int_disable: 1'b1, default: '0};
		end else if (state_ff == boot_pkg::ST_CONFIG) begin
			cfg_ff.int_disable               <= 1'b1;
			cfg_ff.block_zero_program_map    <= 1'b1;
			cfg_ff.single_access_prog_en     <= 1'b1;
			cfg_ff.data_space_overlay_select <= 1'b0;
			cfg_ff.prog_wait     <= boot_pkg::BOOT_WAIT_STATES;
			cfg_ff.data_wait     <= boot_pkg::BOOT_WAIT_STATES;
			cfg_ff.global_mem_en <= 1'b1;
		end else if (state_ff == boot_pkg::ST_FINISH) begin
			cfg_ff.global_mem_en <= 1'b0;
		end
	end

	// ==========================================================
	// Source access timing; the strobe covers the wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			acc_cnt_ff <= '0;
		else if (!reading || acc_done)
			acc_cnt_ff <= '0;
		else
			acc_cnt_ff <= acc_cnt_ff + 4'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gap_cnt_ff <= '0;
		else if (state_ff == boot_pkg::ST_GAP)
			gap_cnt_ff <= gap_cnt_ff + 4'h1;
		else
			gap_cnt_ff <= '0;
	end

	// ==========================================================
	// Selection, header and data capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_ff       <= '0;
			mode_ff      <= boot_pkg::MODE_NONE;
			byte_mode_ff <= 1'b0;
			src_addr_ff  <= '0;
			high_half_ff <= 1'b0;
			high_byte_ff <= '0;
			word_idx_ff  <= '0;
			dest_ff      <= '0;
			len_ff       <= '0;
			word_ff      <= '0;
		end else if (state_ff == boot_pkg::ST_CONFIG) begin
			src_addr_ff  <= boot_pkg::SEL_ADDR;
			word_idx_ff  <= '0;
			high_half_ff <= 1'b0;
			mode_ff      <= boot_pkg::MODE_NONE;
		end else if (state_ff == boot_pkg::ST_SEL_RD && acc_done) begin
			sel_ff <= sel_byte;
		end else if (state_ff == boot_pkg::ST_DECODE) begin
			mode_ff      <= sel_mode;
			byte_mode_ff <= (sel_mode == boot_pkg::MODE_EPROM8);
			src_addr_ff  <= page_addr(sel_page);
			if (sel_mode == boot_pkg::MODE_WARM)
				dest_ff <= page_addr(sel_page);
		end else if (state_ff == boot_pkg::ST_WORD_RD && acc_done) begin
			src_addr_ff <= src_addr_ff + 16'h0001;
			if (need_low) begin
				high_byte_ff <= ext_rdata[7:0];
				high_half_ff <= 1'b1;
			end else begin
				high_half_ff <= 1'b0;
				// Destination, then length, then code words
				unique case (word_idx_ff)
					2'h0: dest_ff <= asm_word;
					2'h1: len_ff  <= asm_word;
					default: word_ff <= asm_word;
				endcase
				if (word_idx_ff != 2'h2)
					word_idx_ff <= word_idx_ff + 2'h1;
			end
		end
	end

	// ==========================================================
	// Program memory write and copy count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			copied_ff  <= '0;
			pm_addr_ff <= '0;
		end else if (state_ff == boot_pkg::ST_DECODE) begin
			copied_ff <= '0;
		end else if (state_ff == boot_pkg::ST_GAP) begin
			pm_addr_ff <= dest_ff + copied_ff;
		end else if (state_ff == boot_pkg::ST_PM_WR) begin
			copied_ff <= copied_ff + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			done_ff <= 1'b0;
		else if (state_ff == boot_pkg::ST_CONFIG)
			done_ff <= 1'b0;
		else if (state_ff == boot_pkg::ST_BRANCH ||
		         state_ff == boot_pkg::ST_HANDOFF)
			done_ff <= 1'b1;
	end

	// ==========================================================
	// APB slave: zero wait states, error on unmapped offsets
	// Restart request is held until the sequencer is idle to take it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			restart_ff <= 1'b0;
		else if (wr_ctrl && pwdata[boot_pkg::CTRL_RESTART])
			restart_ff <= 1'b1;
		else if (soft_start)
			restart_ff <= 1'b0;
	end

	wire [31:0] status_word = {16'h0000, sel_ff, 1'b0, mode_ff, 1'b0,
		mp_pin_ff, done_ff, boot_busy};
	wire [31:0] rd_mux =
		hit_ctrl   ? {31'h00000000, restart_ff} :
		hit_status ? status_word :
		hit_count  ? {16'h0000, copied_ff} :
		hit_target ? {16'h0000, dest_ff} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= '0;
		else if (apb_setup && !pwrite)
			prdata <= rd_mux;
	end

	assign pready  = 1'b1;
	assign pslverr = apb_access && !hit_any;

	// ==========================================================
	// Outputs
	assign ext_req = '{addr: src_addr_ff,
		global_bus_request_n: !reading,
		data_space_strobe_n: !(reading && acc_cnt_ff != 4'h0)};
	assign boot_cfg      = cfg_ff;
	assign global_hit    = cfg_ff.global_mem_en &&
	                       (src_addr_ff >= boot_pkg::GLOBAL_LO);
	assign pm_addr       = pm_addr_ff;
	assign pm_wdata      = word_ff;
	assign pm_we         = (state_ff == boot_pkg::ST_PM_WR);
	assign branch_valid  = (state_ff == boot_pkg::ST_BRANCH);
	assign branch_addr   = dest_ff;
	assign handoff_valid = (state_ff == boot_pkg::ST_HANDOFF);
	assign handoff_mode  = mode_ff;
	assign boot_busy     = (state_ff != boot_pkg::ST_IDLE);

endmodule : boot_loader_sequencer

//--- sim/boot_loader_sequencer_checker.sv
// Port-level assertions for the boot sequencer
`timescale 1ns/1ns

module boot_loader_sequencer_checker (
	// Clock and reset
	input wire logic                pclk,
	input wire logic                presetn,
	// Register port
	input wire logic                psel,
	input wire logic                penable,
	input wire logic [7:0]          paddr,
	input wire logic                pslverr,
	// Boot side
	input wire boot_pkg::ext_req_s  ext_req,
	input wire logic                pm_we,
	input wire logic                global_hit,
	input wire boot_pkg::boot_cfg_s boot_cfg,
	input wire logic                branch_valid,
	input wire logic                handoff_valid,
	input wire logic                boot_busy
);
	wire logic rd_n = ext_req.global_bus_request_n;
	wire logic st_n = ext_req.data_space_strobe_n;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================================
	// External read cycle
	property p_strobe_in_req;
		!st_n |-> !rd_n;
	endproperty
	a_strobe_in_req: assert property (p_strobe_in_req)
		else $error("strobe low without bus request");
	property p_strobe_len;
		$fell(st_n) |-> !st_n [*8] ##1 st_n;
	endproperty
	a_strobe_len: assert property (p_strobe_len)
		else $error("strobe width is not eight cycles");
	property p_addr_hold;
		!st_n |-> $stable(ext_req.addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("source address moved during strobe");

	// ==========================================================
	// Configuration while booting
	property p_cfg;
		!rd_n |-> boot_cfg.int_disable && boot_cfg.block_zero_program_map
			&& boot_cfg.single_access_prog_en
			&& !boot_cfg.data_space_overlay_select;
	endproperty
	a_cfg: assert property (p_cfg)
		else $error("memory setup wrong during read");
	property p_wait;
		!rd_n |-> boot_cfg.prog_wait == 3'h7 && boot_cfg.data_wait == 3'h7;
	endproperty
	a_wait: assert property (p_wait)
		else $error("wait states not seven");
	property p_global;
		!rd_n |-> boot_cfg.global_mem_en;
	endproperty
	a_global: assert property (p_global)
		else $error("global memory off during read");
	property p_global_hit;
		!rd_n |-> global_hit == (ext_req.addr >= 16'h8000);
	endproperty
	a_global_hit: assert property (p_global_hit)
		else $error("global memory decode wrong during read");

	// ==========================================================
	// Copy and hand-over
	property p_gap;
		pm_we |-> $past(st_n, 1) && $past(st_n, 2) && $past(st_n, 3)
			&& $past(st_n, 4);
	endproperty
	a_gap: assert property (p_gap)
		else $error("write too soon after read");
	property p_disable;
		branch_valid |-> !boot_cfg.global_mem_en;
	endproperty
	a_disable: assert property (p_disable)
		else $error("global memory on at branch");
	property p_branch_end;
		branch_valid |=> !branch_valid ##[0:3] !boot_busy;
	endproperty
	a_branch_end: assert property (p_branch_end)
		else $error("sequencer busy after branch");
	property p_slverr;
		psel && penable && paddr == 8'h20 |-> pslverr;
	endproperty
	a_slverr: assert property (p_slverr)
		else $error("unmapped access not refused");

	c_write: cover property (pm_we);
	c_branch: cover property (branch_valid);
	c_handoff: cover property (handoff_valid);
	c_refuse: cover property (pslverr);
endmodule : boot_loader_sequencer_checker

bind boot_loader_sequencer boot_loader_sequencer_checker
	i_boot_loader_sequencer_checker (.pclk, .presetn, .psel, .penable,
	.paddr, .pslverr, .ext_req, .pm_we, .global_hit, .boot_cfg, .branch_valid,
	.handoff_valid, .boot_busy);

//--- sim/boot_eprom_model.sv
// Behavioural source memory on the global data bus
`timescale 1ns/1ns

module boot_eprom_model (
	// Clock
	input wire logic               pclk,
	// Bus from the sequencer
	input wire boot_pkg::ext_req_s ext_req,
	output logic [15:0]            ext_rdata
);
	logic [15:0] mem [0:65535];
	logic [15:0] last_ff = 16'h0000;
	wire  logic  sel = !ext_req.global_bus_request_n
		&& !ext_req.data_space_strobe_n;

	// Released bus flips every cycle, so stale data never passes
	assign ext_rdata = sel ? mem[ext_req.addr] : ~last_ff;
	always @(posedge pclk) last_ff <= ext_rdata;
endmodule : boot_eprom_model

//--- sim/testbench.sv
// Self-checking bench for the boot sequencer
`timescale 1ns/1ns

module testbench;
	logic                 pclk, presetn, psel, penable, pwrite;
	logic [7:0]           paddr;
	logic [31:0]          pwdata, prdata;
	logic                 pready, pslverr, strap;
	boot_pkg::ext_req_s   ext_req;
	logic [15:0]          ext_rdata, pm_addr, pm_wdata, branch_addr;
	logic                 pm_we, global_hit, branch_valid;
	logic                 handoff_valid, boot_busy;
	boot_pkg::boot_cfg_s  boot_cfg;
	boot_pkg::boot_mode_e handoff_mode, ho_cap;
	logic [31:0]          pm_q [$];
	logic [15:0]          br_cap;
	int                   n_br, n_ho, n_fail, n_compared, cycles;

	boot_loader_sequencer i_boot_loader_sequencer (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr),
		.microcomputer_mode_pin(strap), .ext_req(ext_req),
		.ext_rdata(ext_rdata), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
		.pm_we(pm_we), .boot_cfg(boot_cfg), .global_hit(global_hit),
		.branch_valid(branch_valid), .branch_addr(branch_addr),
		.handoff_valid(handoff_valid), .handoff_mode(handoff_mode),
		.boot_busy(boot_busy));
	boot_eprom_model i_boot_eprom_model (.pclk(pclk), .ext_req(ext_req),
		.ext_rdata(ext_rdata));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// ==========================================================
	// Capture and watchdog
	always @(posedge pclk) begin
		cycles++;
		if (pm_we === 1'b1)
			pm_q.push_back({pm_addr, pm_wdata});
		if (branch_valid === 1'b1) begin
			br_cap = branch_addr;
			n_br++;
		end
		if (handoff_valid === 1'b1) begin
			ho_cap = handoff_mode;
			n_ho++;
		end
		if (cycles == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic cmp_val(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp_val

	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Byte images carry junk in the upper lane, which must be ignored
	task automatic load(input logic [15:0] base, input logic [15:0] w[$],
		input logic bytes);
		foreach (w[i])
			if (bytes) begin
				i_boot_eprom_model.mem[base + 16'(2 * i)] = {8'hee, w[i][15:8]};
				i_boot_eprom_model.mem[base + 16'(2 * i + 1)] = {8'hee, w[i][7:0]};
			end else
				i_boot_eprom_model.mem[base + 16'(i)] = w[i];
	endtask : load

	task automatic wait_boot();
		while (boot_busy !== 1'b1) @(posedge pclk);
		while (boot_busy !== 1'b0) @(posedge pclk);
	endtask : wait_boot

	task automatic restart(input logic [15:0] sel);
		logic [31:0] q;
		logic        e;
		i_boot_eprom_model.mem[16'hffff] = sel;
		pm_q.delete();
		n_br = 0;
		n_ho = 0;
		apb(boot_pkg::REG_CTRL, 1'b1, 32'h1, q, e);
		wait_boot();
	endtask : restart

	task automatic check_copy(input logic [15:0] dest, input logic [15:0] w[$]);
		cmp_val(32'(w.size()), 32'(pm_q.size()));
		foreach (w[k])
			cmp_val({dest + 16'(k), w[k]}, pm_q[k]);
		cmp_val(32'(dest), 32'(br_cap));
		cmp_val(32'h1, 32'(n_br));
	endtask : check_copy

	// ==========================================================
	// Scenarios
	task automatic t_word();
		logic [31:0] q;
		logic        e;
		load(16'h8400, '{16'h0100, 16'h0002, 16'h1234, 16'habcd,
			16'h0f0f}, 1'b0);
		i_boot_eprom_model.mem[16'hffff] = 16'h5a86;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		wait_boot();
		check_copy(16'h0100, '{16'h1234, 16'habcd, 16'h0f0f});
		cmp_val(32'h0, 32'(boot_cfg.global_mem_en));
		apb(boot_pkg::REG_COUNT, 1'b0, 32'h0, q, e);
		cmp_val(32'h3, {16'h0, q[15:0]});
		$display("test word_eprom done");
	endtask : t_word

	task automatic t_byte();
		load(16'hc000, '{16'h0200, 16'h0001, 16'hbeef, 16'h55aa}, 1'b1);
		restart(16'h33c1);
		check_copy(16'h0200, '{16'hbeef, 16'h55aa});
		$display("test byte_eprom done");
	endtask : t_byte

	task automatic t_warm();
		restart(16'h772f);
		cmp_val(32'h0, 32'(pm_q.size()));
		cmp_val(32'h2c00, 32'(br_cap));
		$display("test warm done");
	endtask : t_warm

	task automatic t_serial();
		boot_pkg::boot_mode_e m [4];
		m = '{boot_pkg::MODE_SER8, boot_pkg::MODE_SER16,
			boot_pkg::MODE_IO8, boot_pkg::MODE_IO16};
		for (int i = 0; i < 4; i++) begin
			restart({8'h3c, 4'ha, 2'(i), 2'b00});
			cmp_val(32'h1, 32'(n_ho));
			cmp_val(32'(m[i]), 32'(ho_cap));
			cmp_val(32'h0, 32'(pm_q.size()));
		end
		$display("test serial_io done");
	endtask : t_serial

	task automatic t_apb();
		logic [31:0] q;
		logic        e;
		apb(boot_pkg::REG_STATUS, 1'b0, 32'h0, q, e);
		cmp_val(32'hac, {24'h0, q[15:8]});
		cmp_val(32'(boot_pkg::MODE_IO16), {29'h0, q[6:4]});
		cmp_val(32'h2, {29'h0, q[2:0]});
		apb(8'h20, 1'b1, 32'hffff_ffff, q, e);
		cmp_val(32'h1, {31'h0, e});
		apb(8'h20, 1'b0, 32'h0, q, e);
		cmp_val(32'h0, q);
		$display("test register_port done");
	endtask : t_apb

	// Strap high at reset: no boot, even when the pin falls later
	task automatic t_strap();
		logic [31:0] q;
		logic        e;
		presetn <= 1'b0;
		strap   <= 1'b1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		strap <= 1'b0;
		repeat (4) @(posedge pclk);
		cmp_val(32'h0, {31'h0, boot_busy});
		apb(boot_pkg::REG_STATUS, 1'b0, 32'h0, q, e);
		cmp_val(32'h4, {29'h0, q[2:0]});
		$display("test strap_high done");
	endtask : t_strap

	task automatic tally_and_finish();
		$display("compared %0d, mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		strap = 1'b0;
		t_word();
		t_byte();
		t_warm();
		t_serial();
		t_apb();
		t_strap();
		tally_and_finish();
	end
endmodule : testbench
